// [core/timers_with_watchdog.sv]
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - time format packs hours, minutes, seconds, ticks
// - timer0 is 16-bit down counter, core clock
// - timer0 control bit 7 enables, reset cleared
// - timer0 control bit 6 selects periodic mode
// - timer0 prescale 1/16/256, code 11 as 00
// - timer0 value reads live, resets to ffff
// - any write to timer0 clear drops interrupt, unless an event falls in that cycle
// - timer2 source: crystal, oscillator or core clock
// - timer2 bit 8 selects up counting
// - timer2 bit 7 enable, bit 6 periodic
// - timer2 format: binary, 23-hour or 255-hour time
// - timer2 prescale 1/16/256/32768 by code
// - any write to timer2 clear drops interrupt, unless an event falls in that cycle
// - watchdog normal mode like timer0, 32 kHz, up
// - control bit 5 enters watchdog mode, counts down
// - expiry gives reset or interrupt by bit 1
// - service write reloads counter, new timeout
// - watchdog mode locks load and control until reset
// - watchdog mode runs from 32 kHz tick
// - watchdog value resets ffff, load resets 0000
// - free-running counters wrap around at the ends
// - periodic counters restart from load register
// - interrupt when count reaches zero counting down or full counting up
module timers_with_watchdog
   import timers_pkg::*;
(
   input wire logic I_SYS_CLK,
   input wire logic I_RESET,
   input wire logic I_CLK_EN,
   input wire logic I_XTAL_CLK,
   input wire logic I_OSC_CLK,
   input wire logic I_LF_CLK,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [31:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic O_WB_ACK,
   output logic [31:0] O_WB_DAT,
   output logic O_T0_IRQ,
   output logic O_T2_IRQ,
   output logic O_WD_IRQ,
   output logic O_WD_RESET
);
   // prescaler terminal count for the two-bit prescale fields
   function automatic logic [14:0] div_mask2(input logic [1:0] code);
      if (code == PRE2_DIV16) return DIV16_MASK;
      if (code == PRE2_DIV256) return DIV256_MASK;
      return DIV1_MASK; // code 11 falls here and divides by one
   endfunction

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction

   // one tick of the hour:minute:second:tick counter, both directions
   function automatic logic [31:0] time_step(input logic [31:0] v, input logic up,
                                             input logic [7:0] hmax);
      logic [7:0] h;
      logic [5:0] m;
      logic [5:0] s;
      logic [6:0] t;
      h = v[HOUR_LSB +: 8];
      m = v[MIN_LSB +: 6];
      s = v[SEC_LSB +: 6];
      t = v[TICK_LSB +: 7];
      if (up) begin
         if (t != TICK_MAX) t = t + 7'h01;
         else begin
            t = 7'h00;
            if (s != MINSEC_MAX) s = s + 6'h01;
            else begin
               s = 6'h00;
               if (m != MINSEC_MAX) m = m + 6'h01;
               else begin
                  m = 6'h00;
                  h = (h >= hmax) ? 8'h00 : h + 8'h01;
               end
            end
         end
      end else begin
         if (t != 7'h00) t = t - 7'h01;
         else begin
            t = TICK_MAX;
            if (s != 6'h00) s = s - 6'h01;
            else begin
               s = MINSEC_MAX;
               if (m != 6'h00) m = m - 6'h01;
               else begin
                  m = MINSEC_MAX;
                  h = (h == 8'h00) ? hmax : h - 8'h01;
               end
            end
         end
      end
      return {h, 2'b00, m, 2'b00, s, 1'b0, t}; // gaps always zero
   endfunction

   // ---------------- bus slave ----------------
   logic req; // new request, not yet answered
   logic wr; // write strobe for this request
   logic [31:0] rd_data; // read mux result
   logic wr_t0_load, wr_t0_ctl, wr_t0_clr;
   logic wr_t2_load, wr_t2_ctl, wr_t2_clr;
   logic wr_wd_load, wr_wd_ctl, wr_wd_srv;

   assign req = I_CLK_EN & I_WB_CYC & I_WB_STB & ~O_WB_ACK;
   assign wr = req & I_WB_WE;
   assign wr_t0_load = wr && I_WB_ADR == T0_LOAD_ADR;
   assign wr_t0_ctl = wr && I_WB_ADR == T0_CTRL_ADR;
   assign wr_t0_clr = wr && I_WB_ADR == T0_CLR_ADR; // data ignored
   assign wr_t2_load = wr && I_WB_ADR == T2_LOAD_ADR;
   assign wr_t2_ctl = wr && I_WB_ADR == T2_CTRL_ADR;
   assign wr_t2_clr = wr && I_WB_ADR == T2_CLR_ADR; // data ignored
   assign wr_wd_load = wr && I_WB_ADR == WD_LOAD_ADR;
   assign wr_wd_ctl = wr && I_WB_ADR == WD_CTRL_ADR;
   assign wr_wd_srv = wr && I_WB_ADR == WD_SRV_ADR;

   // timer state, declared here so the read mux can see it
   logic [15:0] t0_load, t0_val;
   t0_ctrl_t t0_ctl;
   logic [31:0] t2_load, t2_val;
   t2_ctrl_t t2_ctl;
   logic [15:0] wd_load, wd_val;
   wd_ctrl_t wd_ctl;

   // byte-lane merged write words; a function result cannot be part-selected directly
   logic [31:0] m_t0_load, m_t0_ctl, m_t2_ctl, m_wd_load, m_wd_ctl;
   t2_ctrl_t t2_ctl_new; // timer2 control as it stands after this write
   assign m_t0_load = merge({16'h0000, t0_load}, I_WB_DAT, I_WB_SEL);
   assign m_t0_ctl = merge({24'h00_0000, t0_ctl}, I_WB_DAT, I_WB_SEL);
   assign m_t2_ctl = merge({21'h00_0000, t2_ctl}, I_WB_DAT, I_WB_SEL);
   assign m_wd_load = merge({16'h0000, wd_load}, I_WB_DAT, I_WB_SEL);
   assign m_wd_ctl = merge({23'h00_0000, wd_ctl}, I_WB_DAT, I_WB_SEL);
   assign t2_ctl_new = m_t2_ctl[10:0];

   // read mux; unmapped and write-only addresses read zero
   always_comb begin
      case (I_WB_ADR)
         T0_LOAD_ADR: rd_data = {16'h0000, t0_load};
         T0_VALUE_ADR: rd_data = {16'h0000, t0_val}; // live count
         T0_CTRL_ADR: rd_data = {24'h00_0000, t0_ctl};
         T2_LOAD_ADR: rd_data = t2_load;
         T2_VALUE_ADR: rd_data = t2_val;
         T2_CTRL_ADR: rd_data = {21'h00_0000, t2_ctl};
         WD_LOAD_ADR: rd_data = {16'h0000, wd_load};
         WD_VALUE_ADR: rd_data = {16'h0000, wd_val};
         WD_CTRL_ADR: rd_data = {23'h00_0000, wd_ctl};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // one wait state: ack and data the edge after the request, ack drops next
   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h0000_0000;
      end else if (I_CLK_EN) begin
         O_WB_ACK <= req;
         if (req && !I_WB_WE) O_WB_DAT <= rd_data;
      end
   end

   // ---------------- pin clock synchronisers ----------------
   // order: 0 crystal, 1 internal oscillator, 2 32 kHz
   logic [2:0] src_pin, sync1, sync2, sync3, agreed, rise;
   assign src_pin = {I_LF_CLK, I_OSC_CLK, I_XTAL_CLK};
   genvar g;
   for (g = 0; g < 3; g++) begin : g_sync
      // a rising edge counts once stages two and three agree on high
      always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
         if (I_RESET) begin
            sync1[g] <= 1'b0;
            sync2[g] <= 1'b0;
            sync3[g] <= 1'b0;
            agreed[g] <= 1'b0;
         end else if (I_CLK_EN) begin
            sync1[g] <= src_pin[g];
            sync2[g] <= sync1[g];
            sync3[g] <= sync2[g];
            if (sync2[g] == sync3[g]) agreed[g] <= sync3[g];
         end
      end
      assign rise[g] = sync2[g] & sync3[g] & ~agreed[g];
   end

   // ---------------- timer0 ----------------
   logic [14:0] t0_pre; // prescale divider
   logic t0_hit, t0_run, t0_evt;
   logic [15:0] next_t0_val;

   always_comb begin
      t0_hit = (t0_pre == div_mask2(t0_ctl.prescale));
      t0_run = I_CLK_EN & t0_ctl.enable & t0_hit;
      // periodic restarts from load; free-running wraps 0 -> ffff
      if (t0_ctl.periodic && t0_val == 16'h0000) next_t0_val = t0_load;
      else next_t0_val = t0_val - 16'h0001; // down only
      t0_evt = t0_run && next_t0_val == 16'h0000;
   end

   // timer0 registers; a control write restarts the count from load
   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         t0_load <= LOAD16_RESET;
         t0_ctl <= '0;
         t0_val <= VAL16_RESET;
      end else begin
         if (wr_t0_load) t0_load <= m_t0_load[15:0];
         if (wr_t0_ctl) begin
            t0_ctl <= m_t0_ctl[7:0] & T0_CTRL_MASK;
            t0_val <= t0_load;
         end else if (t0_run) t0_val <= next_t0_val;
      end
   end

   // prescaler is held clear while stopped so each start sees a full period
   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) t0_pre <= DIV1_MASK;
      else if (I_CLK_EN) begin
         if (!t0_ctl.enable || wr_t0_ctl || t0_hit) t0_pre <= DIV1_MASK;
         else t0_pre <= t0_pre + 15'h0001;
      end
   end

   // pending flag: an event in the clearing cycle wins
   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) O_T0_IRQ <= 1'b0;
      else if (t0_evt) O_T0_IRQ <= 1'b1;
      else if (wr_t0_clr) O_T0_IRQ <= 1'b0;
   end

   // ---------------- timer2 ----------------
   logic [14:0] t2_pre, t2_mask;
   logic t2_src_tick, t2_hit, t2_run, t2_evt, t2_time;
   logic [7:0] t2_hmax;
   logic [31:0] t2_full, t2_target, t2_reload, next_t2_val;

   always_comb begin
      // source select: crystal for 00/01, oscillator 10, core 11
      case (t2_ctl.source)
         SRC_OSC: t2_src_tick = rise[1];
         SRC_CORE: t2_src_tick = 1'b1;
         default: t2_src_tick = rise[0];
      endcase
      case (t2_ctl.prescale) // unlisted codes divide by one
         PRE4_DIV16: t2_mask = DIV16_MASK;
         PRE4_DIV256: t2_mask = DIV256_MASK;
         PRE4_DIV32K: t2_mask = DIV32K_MASK;
         default: t2_mask = DIV1_MASK;
      endcase
      t2_hit = t2_src_tick && t2_pre == t2_mask;
      t2_run = I_CLK_EN & t2_ctl.enable & t2_hit;
      // format 01 is reserved and counts as binary
      t2_time = t2_ctl.format[1];
      t2_hmax = (t2_ctl.format == FMT_TIME_DAY) ? HOUR_MAX_DAY : HOUR_MAX_FULL;
      t2_full = t2_time ? {t2_hmax, 2'b00, MINSEC_MAX, 2'b00, MINSEC_MAX, 1'b0, TICK_MAX}
                        : VAL32_RESET;
      t2_target = t2_ctl.count_up ? t2_full : 32'h0000_0000;
      t2_reload = t2_time ? (t2_load & TIME_MASK) : t2_load;
      if (t2_ctl.periodic && t2_val == t2_target) next_t2_val = t2_reload;
      else if (t2_time) next_t2_val = time_step(t2_val, t2_ctl.count_up, t2_hmax);
      else if (t2_ctl.count_up) next_t2_val = t2_val + 32'h0000_0001; // wraps
      else next_t2_val = t2_val - 32'h0000_0001;
      t2_evt = t2_run && next_t2_val == t2_target;
   end

   // timer2 registers
   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         t2_load <= LOAD32_RESET;
         t2_ctl <= '0;
         t2_val <= VAL32_RESET;
      end else begin
         if (wr_t2_load) t2_load <= merge(t2_load, I_WB_DAT, I_WB_SEL);
         if (wr_t2_ctl) begin
            t2_ctl <= t2_ctl_new;
            // mask by the format being written, so gap bits never reach the count
            t2_val <= t2_ctl_new.format[1] ? (t2_load & TIME_MASK) : t2_load;
         end else if (t2_run) t2_val <= next_t2_val;
      end
   end

   // timer2 prescaler advances only on source ticks
   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) t2_pre <= DIV1_MASK;
      else if (I_CLK_EN) begin
         if (!t2_ctl.enable || wr_t2_ctl || t2_hit) t2_pre <= DIV1_MASK;
         else if (t2_src_tick) t2_pre <= t2_pre + 15'h0001;
      end
   end

   // timer2 pending flag, set wins over clear
   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) O_T2_IRQ <= 1'b0;
      else if (t2_evt) O_T2_IRQ <= 1'b1;
      else if (wr_t2_clr) O_T2_IRQ <= 1'b0;
   end

   // ---------------- watchdog ----------------
   logic [14:0] wd_pre;
   logic wd_hit, wd_run, wd_evt, wd_up, wd_per, wd_lock;
   logic [15:0] wd_target, next_wd_val;

   always_comb begin
      wd_lock = wd_ctl.wd_mode; // only reset leaves this
      wd_hit = rise[2] && wd_pre == div_mask2(wd_ctl.prescale); // 32 kHz
      wd_run = I_CLK_EN & (wd_ctl.enable | wd_lock) & wd_hit;
      wd_up = wd_ctl.count_up & ~wd_lock; // watchdog mode always counts down
      wd_per = wd_ctl.periodic | wd_lock; // expiry reloads the timeout
      wd_target = wd_up ? VAL16_RESET : 16'h0000;
      if (wd_per && wd_val == wd_target) next_wd_val = wd_load;
      else if (wd_up) next_wd_val = wd_val + 16'h0001;
      else next_wd_val = wd_val - 16'h0001;
      wd_evt = wd_run && next_wd_val == wd_target;
   end

   // watchdog registers; load and control ignore writes while locked
   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         wd_load <= LOAD16_RESET;
         wd_ctl <= '0;
         wd_val <= VAL16_RESET;
      end else begin
         if (wr_wd_load && !wd_lock) begin
            wd_load <= m_wd_load[15:0];
         end
         // the counter takes the load already written, so load must come first
         if (wr_wd_ctl && !wd_lock) begin
            wd_ctl <= m_wd_ctl[8:0] & WD_CTRL_MASK;
            wd_val <= wd_load;
         end else if (wr_wd_srv && wd_lock) wd_val <= wd_load; // fresh timeout
         else if (wd_run) wd_val <= next_wd_val;
      end
   end

   // watchdog prescaler on 32 kHz ticks; a service also restarts it
   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) wd_pre <= DIV1_MASK;
      else if (I_CLK_EN) begin
         if (!(wd_ctl.enable | wd_lock) || wr_wd_ctl || wr_wd_srv || wd_hit) wd_pre <= DIV1_MASK;
         else if (rise[2]) wd_pre <= wd_pre + 15'h0001;
      end
   end

   // expiry: reset request is sticky until the system reset arrives
   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_WD_IRQ <= 1'b0;
         O_WD_RESET <= 1'b0;
      end else begin
         if (wd_evt && wd_lock && !wd_ctl.irq_not_reset) O_WD_RESET <= 1'b1;
         if (wd_evt && (!wd_lock || wd_ctl.irq_not_reset)) O_WD_IRQ <= 1'b1;
         else if (wr_wd_srv) O_WD_IRQ <= 1'b0;
      end
   end

   // ---------------- assertions ----------------
   sequence s_service;
      wr_wd_srv && wd_lock;
   endsequence
   sequence s_locked_write;
      (wr_wd_load || wr_wd_ctl) && wd_lock;
   endsequence

   property p_wb_ack;
      @(posedge I_SYS_CLK) disable iff (I_RESET) req |=> O_WB_ACK ##1 !O_WB_ACK;
   endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("bus ack not one cycle");
   property p_t0_clear;
      @(posedge I_SYS_CLK) disable iff (I_RESET) wr_t0_clr && !t0_evt |=> !O_T0_IRQ;
   endproperty
   a_t0_clear: assert property (p_t0_clear) else $error("timer0 irq not cleared");
   property p_t0_stopped;
      @(posedge I_SYS_CLK) disable iff (I_RESET)
         !t0_ctl.enable && !wr_t0_ctl |=> $stable(t0_val);
   endproperty
   a_t0_stopped: assert property (p_t0_stopped) else $error("timer0 runs while off");
   property p_t0_div1;
      @(posedge I_SYS_CLK) disable iff (I_RESET)
         I_CLK_EN && t0_ctl.enable && t0_ctl.prescale inside {2'b00, 2'b11}
         && !wr_t0_ctl && t0_val != 16'h0000 |=> t0_val == $past(t0_val) - 16'h0001;
   endproperty
   a_t0_div1: assert property (p_t0_div1) else $error("timer0 divide by one wrong");
   property p_t0_read;
      @(posedge I_SYS_CLK) disable iff (I_RESET)
         req && !I_WB_WE && I_WB_ADR == T0_VALUE_ADR |=> O_WB_DAT == {16'h0000, $past(t0_val)};
   endproperty
   a_t0_read: assert property (p_t0_read) else $error("timer0 value read wrong");
   property p_t2_up;
      @(posedge I_SYS_CLK) disable iff (I_RESET)
         t2_run && !t2_time && t2_ctl.count_up && !t2_ctl.periodic && !wr_t2_ctl
         |=> t2_val == $past(t2_val) + 32'h0000_0001;
   endproperty
   a_t2_up: assert property (p_t2_up) else $error("timer2 up count wrong");
   property p_t2_gaps;
      @(posedge I_SYS_CLK) disable iff (I_RESET)
         t2_run && t2_time && !wr_t2_ctl |=> (t2_val & ~TIME_MASK) == 32'h0000_0000;
   endproperty
   a_t2_gaps: assert property (p_t2_gaps) else $error("time format gap bits set");
   property p_wd_lock;
      @(posedge I_SYS_CLK) disable iff (I_RESET) s_locked_write |=> $stable(wd_load) && $stable(wd_ctl);
   endproperty
   a_wd_lock: assert property (p_wd_lock) else $error("locked watchdog register changed");
   property p_wd_service;
      @(posedge I_SYS_CLK) disable iff (I_RESET) s_service |=> wd_val == $past(wd_load);
   endproperty
   a_wd_service: assert property (p_wd_service) else $error("service did not reload");
   property p_wd_reset;
      @(posedge I_SYS_CLK) disable iff (I_RESET)
         wd_evt && wd_lock && !wd_ctl.irq_not_reset |=> O_WD_RESET [*2];
   endproperty
   a_wd_reset: assert property (p_wd_reset) else $error("expiry gave no reset");
endmodule // timers_with_watchdog

// [shared/timers_pkg.sv]
package timers_pkg;
   // register byte addresses on the bus
   localparam logic [31:0] T0_LOAD_ADR = 32'hffff_0300;
   localparam logic [31:0] T0_VALUE_ADR = 32'hffff_0304;
   localparam logic [31:0] T0_CTRL_ADR = 32'hffff_0308;
   localparam logic [31:0] T0_CLR_ADR = 32'hffff_030c;
   localparam logic [31:0] T2_LOAD_ADR = 32'hffff_0340;
   localparam logic [31:0] T2_VALUE_ADR = 32'hffff_0344;
   localparam logic [31:0] T2_CTRL_ADR = 32'hffff_0348;
   localparam logic [31:0] T2_CLR_ADR = 32'hffff_034c;
   localparam logic [31:0] WD_LOAD_ADR = 32'hffff_0360;
   localparam logic [31:0] WD_VALUE_ADR = 32'hffff_0364;
   localparam logic [31:0] WD_CTRL_ADR = 32'hffff_0368;
   localparam logic [31:0] WD_SRV_ADR = 32'hffff_036c;
   // values after reset
   localparam logic [15:0] VAL16_RESET = 16'hffff;
   localparam logic [15:0] LOAD16_RESET = 16'h0000;
   localparam logic [31:0] VAL32_RESET = 32'hffff_ffff;
   localparam logic [31:0] LOAD32_RESET = 32'h0000_0000;
   // time format fields and limits
   localparam int HOUR_LSB = 24;
   localparam int MIN_LSB = 16;
   localparam int SEC_LSB = 8;
   localparam int TICK_LSB = 0;
   localparam logic [7:0] HOUR_MAX_DAY = 8'h17;
   localparam logic [7:0] HOUR_MAX_FULL = 8'hff;
   localparam logic [5:0] MINSEC_MAX = 6'h3b;
   localparam logic [6:0] TICK_MAX = 7'h7f;
   localparam logic [31:0] TIME_MASK = 32'hff3f_3f7f;
   // prescaler terminal counts and their codes, then the format and source codes
   localparam logic [14:0] DIV1_MASK = 15'h0000;
   localparam logic [14:0] DIV16_MASK = 15'h000f;
   localparam logic [14:0] DIV256_MASK = 15'h00ff;
   localparam logic [14:0] DIV32K_MASK = 15'h7fff;
   localparam logic [1:0] PRE2_DIV16 = 2'h1;
   localparam logic [1:0] PRE2_DIV256 = 2'h2;
   localparam logic [3:0] PRE4_DIV16 = 4'h4;
   localparam logic [3:0] PRE4_DIV256 = 4'h8;
   localparam logic [3:0] PRE4_DIV32K = 4'hf;
   localparam logic [1:0] FMT_TIME_DAY = 2'h2;
   localparam logic [1:0] SRC_OSC = 2'h2;
   localparam logic [1:0] SRC_CORE = 2'h3;
   // writable bits of the control registers
   localparam logic [7:0] T0_CTRL_MASK = 8'hcc;
   localparam logic [8:0] WD_CTRL_MASK = 9'h1ee;
   // control register layouts, msb first
   typedef struct packed {
      logic enable; logic periodic; logic [1:0] rsvd_hi;
      logic [1:0] prescale; logic [1:0] rsvd_lo;
   } t0_ctrl_t;
   typedef struct packed {
      logic [1:0] source; logic count_up; logic enable; logic periodic;
      logic [1:0] format; logic [3:0] prescale;
   } t2_ctrl_t;
   typedef struct packed {
      logic count_up; logic enable; logic periodic; logic wd_mode; logic rsvd4;
      logic [1:0] prescale; logic irq_not_reset; logic rsvd0;
   } wd_ctrl_t;
endpackage

// [sim/timers_with_watchdog_bench.sv]
`timescale 1ns/1ps
module timers_with_watchdog_bench;
   import timers_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic lf = 1'b0;
   logic xt = 1'b0;
   logic osc = 1'b0;
   logic ce = 1'b1; // clock enable, dropped once to check the freeze
   logic [31:0] snap; // value seen before the freeze
   logic [3:0] div = 4'h0;
   logic [31:0] adr = 32'h0000_0000;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] rdat; // data taken at the ack edge
   logic ack;
   logic [31:0] q;
   logic t0i, t2i, wdi, wdr;
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   int pc[4] = '{0, 4, 8, 15}; // timer2 prescale codes
   int pd[4] = '{1, 16, 256, 32768}; // their divide ratios

   always #25 clk = ~clk;

   // side clocks from a free divider: crystal /4, 32 kHz pin /8, oscillator /16
   always @(posedge clk) begin
      div <= div + 4'h1;
      xt <= div[1];
      lf <= div[2];
      osc <= div[3];
   end

   // hang guard, far above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   timers_with_watchdog dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_CLK_EN(ce),
      .I_XTAL_CLK(xt), .I_OSC_CLK(osc), .I_LF_CLK(lf), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(dat), .O_WB_ACK(ack),
      .O_WB_DAT(q), .O_T0_IRQ(t0i), .O_T2_IRQ(t2i), .O_WD_IRQ(wdi), .O_WD_RESET(wdr));

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // range compare: an unknown never counts as inside
   task automatic chk_in(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                         input logic [31:0] g);
      cmp_count++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h..%h seen %h", nm, lo, hi, g);
      end
   endtask

   // classic single cycle; holds everything until ack is sampled high
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rdat = q;
      chk("bus ack", 32'h1, {31'h0, ack});
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, e, rdat);
   endtask

   // control write reloads from 0x1000; after ~64 cycles the drop tells the step rate
   task automatic run_rate(input logic [31:0] ld_a, input logic [31:0] ct, input int per,
                           input string nm);
      bus(1'b1, ld_a, 32'h0000_1000);
      bus(1'b1, ld_a + 32'h8, ct);
      repeat (64) @(posedge clk);
      bus(1'b0, ld_a + 32'h4, 32'h0000_0000);
      chk_in(nm, 32'h1000 - 80 / per - 1, 32'h1000 - 48 / per, rdat);
   endtask

   // bounded wait for one of the event outputs
   task automatic wait_flag(input int k, input int lim, input string nm);
      int n;
      logic f;
      n = 0;
      f = 1'b0;
      while (f !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
         f = (k == 0) ? t0i : (k == 1) ? t2i : (k == 2) ? wdi : wdr;
      end
      chk(nm, 32'h1, {31'h0, f});
   endtask

   task automatic do_reset();
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
   endtask

   initial begin
      do_reset();
      rd(T0_LOAD_ADR, 32'h0000_0000, "t0 load");
      bus(1'b1, T0_VALUE_ADR, 32'h0000_1234);
      rd(T0_VALUE_ADR, 32'h0000_ffff, "t0 value");
      rd(T0_CTRL_ADR, 32'h0000_0000, "t0 ctrl");
      rd(WD_LOAD_ADR, 32'h0000_0000, "wd load");
      rd(WD_VALUE_ADR, 32'h0000_ffff, "wd value");
      rd(WD_CTRL_ADR, 32'h0000_0000, "wd ctrl");
      rd(32'hffff_0310, 32'h0000_0000, "unmapped");
      $display("test reset values done");
      for (int p = 0; p < 4; p++)
         run_rate(T0_LOAD_ADR, 32'h80 | (p << 2), (p == 1) ? 16 : (p == 2) ? 256 : 1, "t0 rate");
      for (int s = 0; s < 4; s++)
         run_rate(T2_LOAD_ADR, 32'h80 | (s << 9), (s < 2) ? 4 : (s == 2) ? 16 : 1, "t2 src");
      for (int p = 0; p < 4; p++)
         run_rate(T2_LOAD_ADR, 32'h680 | pc[p], pd[p], "t2 prescale");
      run_rate(WD_LOAD_ADR, 32'h0000_0080, 8, "wd normal");
      $display("test step rates done");
      bus(1'b1, T0_LOAD_ADR, 32'h0000_0003);
      bus(1'b1, T0_CTRL_ADR, 32'h0000_00c0);
      bus(1'b0, T0_VALUE_ADR, 32'h0000_0000);
      chk_in("t0 periodic", 32'h0, 32'h3, rdat);
      wait_flag(0, 40, "t0 irq");
      bus(1'b1, T0_CTRL_ADR, 32'h0000_0040);
      bus(1'b1, T0_CLR_ADR, 32'h0000_005a);
      chk("t0 irq clear", 32'h0, {31'h0, t0i});
      rd(T0_VALUE_ADR, 32'h0000_0003, "t0 stopped");
      bus(1'b1, T0_LOAD_ADR, 32'h0000_0002);
      bus(1'b1, T0_CTRL_ADR, 32'h0000_0080);
      repeat (10) @(posedge clk);
      bus(1'b0, T0_VALUE_ADR, 32'h0000_0000);
      chk_in("t0 wrap", 32'h0000_ffe0, 32'h0000_ffff, rdat);
      // with the enable low for 20 cycles only three steps pass between the reads
      snap = rdat;
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      bus(1'b0, T0_VALUE_ADR, 32'h0000_0000);
      chk_in("clock enable freeze", snap - 32'h4, snap - 32'h2, rdat);
      $display("test timer0 events done");
      bus(1'b1, T2_LOAD_ADR, 32'hffff_ff00);
      bus(1'b1, T2_CTRL_ADR, 32'h0000_0780);
      wait_flag(1, 600, "t2 full scale");
      bus(1'b1, T2_CTRL_ADR, 32'h0000_0700);
      bus(1'b1, T2_CLR_ADR, 32'h0000_00a5);
      chk("t2 irq clear", 32'h0, {31'h0, t2i});
      // load with every gap bit set; entering time format must drop them
      bus(1'b1, T2_LOAD_ADR, 32'h17fb_fbff);
      bus(1'b1, T2_CTRL_ADR, 32'h0000_0720);
      rd(T2_VALUE_ADR, 32'h173b_3b7f, "t2 load masked");
      for (int f = 2; f < 4; f++) begin
         bus(1'b1, T2_LOAD_ADR, 32'h173b_3b7f);
         bus(1'b1, T2_CTRL_ADR, 32'h780 | (f << 4));
         repeat (8) @(posedge clk);
         bus(1'b0, T2_VALUE_ADR, 32'h0000_0000);
         chk("t2 time rollover", (f == 2) ? 32'h0 : 32'h1800_0000, rdat & 32'hff3f_3f00);
         chk("t2 time gaps", 32'h0, rdat & ~TIME_MASK);
      end
      $display("test timer2 done");
      bus(1'b1, WD_LOAD_ADR, 32'h0000_0020);
      bus(1'b1, WD_CTRL_ADR, 32'h0000_0022);
      repeat (3) begin
         repeat (120) @(posedge clk);
         bus(1'b1, WD_SRV_ADR, 32'h0000_0001);
      end
      chk("wd serviced", 32'h0, {31'h0, wdi});
      bus(1'b0, WD_VALUE_ADR, 32'h0000_0000);
      chk_in("wd reloaded", 32'h0000_001c, 32'h0000_0020, rdat);
      bus(1'b1, WD_LOAD_ADR, 32'h0000_0005);
      bus(1'b1, WD_CTRL_ADR, 32'h0000_0000);
      rd(WD_LOAD_ADR, 32'h0000_0020, "wd load locked");
      rd(WD_CTRL_ADR, 32'h0000_0022, "wd ctrl locked");
      wait_flag(2, 400, "wd expiry irq");
      chk("wd no reset", 32'h0, {31'h0, wdr});
      do_reset();
      rd(WD_CTRL_ADR, 32'h0000_0000, "wd mode left");
      bus(1'b1, WD_LOAD_ADR, 32'h0000_0008);
      bus(1'b1, WD_CTRL_ADR, 32'h0000_0020);
      wait_flag(3, 200, "wd expiry reset");
      chk("wd no irq", 32'h0, {31'h0, wdi});
      $display("test watchdog done");
      wrap_up();
   end
endmodule // timers_with_watchdog_bench
